// File: abr_media_model.sv
`timescale 1ns/1ps
`default_nettype none
module abr_media_model (
    input  wire logic                ref_clk,    // Clock
    input  wire logic                rst,        // Reset
    input  wire abr_pkg::abr_media_s media,      // Fetch request
    input  wire logic                flush_req,  // Commit request
    input  wire logic                slow,       // Stretch latency
    output logic                     media_ack,  // Sector ready
    output logic [15:0]              media_word, // Buffer word
    output logic                     flush_ack,  // Commit done
    output int                       n_ack,      // Fills served
    output int                       n_flush     // Commits served
);
    int  wait_q;
    wire logic want = media.req || flush_req;

    assign media_word = 16'hc3a5;

    // ==========================================================
    // Request service
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wait_q <= 0;
            media_ack <= 1'b0;
            flush_ack <= 1'b0;
            n_ack <= 0;
            n_flush <= 0;
        end else begin
            media_ack <= 1'b0;
            flush_ack <= 1'b0;
            // Gap after each answer so a level request is not served twice
            if (media_ack || flush_ack) begin
                wait_q <= 0;
            end else if (want && wait_q < (slow ? 6 : 1)) begin
                wait_q <= wait_q + 1;
            end else if (flush_req) begin
                flush_ack <= 1'b1;
                n_flush <= n_flush + 1;
            end else if (media.req) begin
                media_ack <= 1'b1;
                n_ack <= n_ack + 1;
            end
        end
    end
endmodule
`default_nettype wire

// File: abr_pkg.sv
package abr_pkg;
    // ==========================================================
    // Task file register indices (plain port address)
    localparam logic [3:0] ADDR_DATA      = 4'h0;
    localparam logic [3:0] ADDR_FEATURES  = 4'h1;
    localparam logic [3:0] ADDR_SECCOUNT  = 4'h2;
    localparam logic [3:0] ADDR_LBA_LOW   = 4'h3;
    localparam logic [3:0] ADDR_LBA_MID   = 4'h4;
    localparam logic [3:0] ADDR_LBA_HIGH  = 4'h5;
    localparam logic [3:0] ADDR_DEVHEAD   = 4'h6;
    localparam logic [3:0] ADDR_COMMAND   = 4'h7;
    localparam logic [3:0] ADDR_DEVCTRL   = 4'h8;
    localparam logic [3:0] ADDR_MULTSIZE  = 4'h9;
    localparam logic [3:0] ADDR_ERRINJ    = 4'ha;
    localparam logic [3:0] ADDR_CACHE     = 4'hb;
    // ==========================================================
    // Opcodes
    localparam logic [7:0] OPC_READ_QUEUED = 8'h60;
    localparam logic [7:0] OPC_READ_MULT   = 8'hc4;
    localparam logic [7:0] OPC_READ_MULT_X = 8'h29;
    // ==========================================================
    // Field positions
    localparam int DH_LBA_BIT  = 6;
    localparam int DH_FUA_BIT  = 7;
    localparam int HOB_BIT     = 7;
    localparam int ST_BSY      = 7;
    localparam int ST_DRDY     = 6;
    localparam int ST_DRQ      = 3;
    localparam int ST_CORR     = 2;
    localparam int ST_ERR      = 0;
    localparam int ER_UNC      = 6;
    localparam int ER_ABRT     = 2;
    localparam int EI_ARM      = 0;
    localparam int EI_CORR     = 1;
    localparam int CC_VALID    = 0;
    localparam int CC_DIRTY    = 1;
    // ==========================================================
    // Sizes and timing
    localparam logic [7:0]  WORDS_PER_SECTOR = 8'hff;   // 256 words - 1
    localparam logic [8:0]  MAX_MULT         = 9'h080;
    localparam logic [16:0] COUNT_28_ZERO    = 17'h00100;
    localparam logic [16:0] COUNT_48_ZERO    = 17'h10000;
    localparam logic [3:0]  FILL_CYCLES      = 4'h4;
    localparam logic [3:0]  FLUSH_CYCLES     = 4'h8;
    localparam logic [7:0]  ST_RESET         = 8'h40;

    typedef enum logic [1:0] {
        ABR_CMD_NONE,
        ABR_CMD_QUEUED,
        ABR_CMD_MULT28,
        ABR_CMD_MULT48
    } abr_cmd_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } abr_bus_s;

    typedef struct packed {
        logic        req;
        logic [47:0] lba;
        logic        from_media;
    } abr_media_s;
endpackage

// File: abr_read_engine.sv
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module abr_read_engine (
    input  wire logic                   ref_clk,    // 100 MHz clock
    input  wire logic                   rst,        // async reset
    input  wire abr_pkg::abr_bus_s      bus,        // register port
    output logic [15:0]                 rdata,      // read data
    output logic                        intrq,      // interrupt level
    output abr_pkg::abr_media_s         media,      // media fetch request
    input  wire logic                   media_ack,  // sector in buffer
    input  wire logic [15:0]            media_word, // buffer word
    output logic                        flush_req,  // commit dirty cache
    input  wire logic                   flush_ack,  // commit done
    output logic [4:0]                  qtag,       // queued tag
    output logic                        q_done      // queued read done
);
    typedef enum logic [2:0] {
        S_IDLE, S_FLUSH, S_FILL, S_XFER, S_DONE
    } abr_state_e;

    abr_state_e         state_q;
    abr_pkg::abr_cmd_e  cmd_q;
    logic [15:0] cnt_prev_q, lo_prev_q, mid_prev_q, hi_prev_q;
    logic [7:0]  feat_cur_q, feat_prev_q, cnt_cur_q;
    logic [7:0]  lo_q, mid_q, hi_q, dh_q, devctl_q, err_q, stat_q;
    logic [8:0]  mult_q;
    logic [1:0]  inj_q;
    logic [1:0]  cache_q;
    logic [47:0] lba_q;
    logic [16:0] remain_q;
    logic [8:0]  blk_left_q;
    logic [7:0]  word_q;
    logic        fatal_q, fua_q, intrq_q;
    logic [15:0] rdata_q;

    wire wr_cmd  = bus.wr && bus.addr == abr_pkg::ADDR_COMMAND;
    wire rd_data = bus.rd && bus.addr == abr_pkg::ADDR_DATA;
    wire rd_stat = bus.rd && bus.addr == abr_pkg::ADDR_COMMAND;
    wire hob     = devctl_q[abr_pkg::HOB_BIT];
    wire idle    = state_q == S_IDLE || state_q == S_DONE;

    // ==========================================================
    // Command decode
    // queued opcode 60h
    wire is_q   = bus.wdata == abr_pkg::OPC_READ_QUEUED;
    wire is_m28 = bus.wdata == abr_pkg::OPC_READ_MULT;
    wire is_m48 = bus.wdata == abr_pkg::OPC_READ_MULT_X;
    // block size must be programmed; size one allowed
    wire mult_ok = mult_q != 9'h000 && mult_q <= abr_pkg::MAX_MULT;
    wire abort   = ((is_m28 || is_m48) && !mult_ok) ||
                   !(is_q || is_m28 || is_m48);

    wire [16:0] cnt28 = (cnt_cur_q == 8'h00) ? abr_pkg::COUNT_28_ZERO
                      : {9'h000, cnt_cur_q};
    wire [16:0] cnt48 = ({cnt_prev_q[7:0], cnt_cur_q} == 16'h0000)
                      ? abr_pkg::COUNT_48_ZERO
                      : {1'b0, cnt_prev_q[7:0], cnt_cur_q};
    wire [16:0] cntq  = ({feat_prev_q, feat_cur_q} == 16'h0000)
                      ? abr_pkg::COUNT_48_ZERO
                      : {1'b0, feat_prev_q, feat_cur_q};

    wire [47:0] lba28 = {20'h00000, dh_q[3:0], hi_q, mid_q, lo_q};
    wire [47:0] lba48 = {hi_prev_q[7:0], mid_prev_q[7:0], lo_prev_q[7:0],
                         hi_q, mid_q, lo_q};
    wire [16:0] start_cnt = is_q ? cntq : (is_m48 ? cnt48 : cnt28);
    wire [47:0] start_lba = is_m28 ? lba28 : lba48;

    // block length is min(block size, remaining); one sector for queued
    wire [8:0] blk_len = (cmd_q == abr_pkg::ABR_CMD_QUEUED) ? 9'h001 :
                         ((remain_q < {8'h00, mult_q}) ? remain_q[8:0]
                                                       : mult_q);

    // FUA ignores cache; non-FUA may use valid cache
    wire use_media = fua_q || !cache_q[abr_pkg::CC_VALID];
    // dirty data committed first under FUA, for queued reads only
    wire need_flush = is_q && dh_q[abr_pkg::DH_FUA_BIT] &&
                      cache_q[abr_pkg::CC_DIRTY];

    wire sector_end = rd_data && state_q == S_XFER &&
                      word_q == abr_pkg::WORDS_PER_SECTOR;
    wire blk_end    = sector_end && blk_left_q == 9'h001;
    wire last_sec   = sector_end && remain_q == 17'h00001;

    // ==========================================================
    // Task file writes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            feat_cur_q  <= 8'h00;
            feat_prev_q <= 8'h00;
            cnt_cur_q   <= 8'h00;
            cnt_prev_q  <= 16'h0000;
            lo_prev_q   <= 16'h0000;
            mid_prev_q  <= 16'h0000;
            hi_prev_q   <= 16'h0000;
            dh_q        <= 8'h00;
            devctl_q    <= 8'h00;
            mult_q      <= 9'h000;
            inj_q       <= 2'b00;
            cache_q     <= 2'b00;
        end else if (bus.wr && idle) begin
            // each features, count or LBA write shifts older byte to previous
            unique case (bus.addr)
                abr_pkg::ADDR_FEATURES: begin
                    feat_prev_q <= feat_cur_q;
                    feat_cur_q  <= bus.wdata;
                end
                abr_pkg::ADDR_SECCOUNT: begin
                    cnt_prev_q <= {8'h00, cnt_cur_q};
                    cnt_cur_q  <= bus.wdata;
                end
                abr_pkg::ADDR_LBA_LOW:  lo_prev_q  <= {8'h00, lo_q};
                abr_pkg::ADDR_LBA_MID:  mid_prev_q <= {8'h00, mid_q};
                abr_pkg::ADDR_LBA_HIGH: hi_prev_q  <= {8'h00, hi_q};
                abr_pkg::ADDR_DEVHEAD:  dh_q       <= bus.wdata;
                abr_pkg::ADDR_DEVCTRL:  devctl_q   <= bus.wdata;
                abr_pkg::ADDR_MULTSIZE: mult_q     <= {1'b0, bus.wdata};
                abr_pkg::ADDR_ERRINJ:   inj_q      <= bus.wdata[1:0];
                abr_pkg::ADDR_CACHE:    cache_q    <= bus.wdata[1:0];
                default: ;
            endcase
        end else if (bus.wr && bus.addr == abr_pkg::ADDR_ERRINJ) begin
            inj_q <= bus.wdata[1:0];
        end else if (state_q == S_FILL && media_ack) begin
            inj_q[abr_pkg::EI_ARM] <= 1'b0;
        end
    end

    // ==========================================================
    // Command sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q    <= S_IDLE;
            cmd_q      <= abr_pkg::ABR_CMD_NONE;
            lba_q      <= 48'h0;
            remain_q   <= 17'h0;
            blk_left_q <= 9'h0;
            word_q     <= 8'h00;
            fatal_q    <= 1'b0;
            fua_q      <= 1'b0;
            stat_q     <= abr_pkg::ST_RESET;
            err_q      <= 8'h00;
            lo_q       <= 8'h00;
            mid_q      <= 8'h00;
            hi_q       <= 8'h00;
        end else begin
            if (bus.wr && idle) begin
                unique case (bus.addr)
                    abr_pkg::ADDR_LBA_LOW:  lo_q  <= bus.wdata;
                    abr_pkg::ADDR_LBA_MID:  mid_q <= bus.wdata;
                    abr_pkg::ADDR_LBA_HIGH: hi_q  <= bus.wdata;
                    default: ;
                endcase
            end
            unique case (state_q)
                S_IDLE, S_DONE: begin
                    if (wr_cmd && abort) begin
                        err_q  <= 8'h00;
                        err_q[abr_pkg::ER_ABRT] <= 1'b1;
                        stat_q <= 8'h00;
                        stat_q[abr_pkg::ST_DRDY] <= 1'b1;
                        stat_q[abr_pkg::ST_ERR]  <= 1'b1;
                        state_q <= S_DONE;
                    end else if (wr_cmd) begin
                        cmd_q <= is_q   ? abr_pkg::ABR_CMD_QUEUED :
                                 is_m48 ? abr_pkg::ABR_CMD_MULT48 :
                                          abr_pkg::ABR_CMD_MULT28;
                        lba_q    <= start_lba;
                        remain_q <= start_cnt;
                        fua_q    <= is_q && dh_q[abr_pkg::DH_FUA_BIT];
                        fatal_q  <= 1'b0;
                        err_q    <= 8'h00;
                        stat_q   <= 8'h00;
                        stat_q[abr_pkg::ST_BSY] <= 1'b1;
                        state_q  <= need_flush ? S_FLUSH : S_FILL;
                    end
                end
                S_FLUSH: begin
                    // wait for commit before media read
                    if (flush_ack) begin
                        state_q <= S_FILL;
                    end
                end
                S_FILL: begin
                    if (media_ack) begin
                        blk_left_q <= blk_len;
                        word_q     <= 8'h00;
                        if (inj_q[abr_pkg::EI_ARM]) begin
                            err_q[abr_pkg::ER_UNC] <= !inj_q[abr_pkg::EI_CORR];
                            fatal_q <= !inj_q[abr_pkg::EI_CORR];
                            {hi_q, mid_q, lo_q} <= lba_q[23:0];
                        end
                        stat_q <= 8'h00;
                        stat_q[abr_pkg::ST_DRDY] <= 1'b1;
                        stat_q[abr_pkg::ST_DRQ]  <= 1'b1;
                        stat_q[abr_pkg::ST_ERR]  <= inj_q[abr_pkg::EI_ARM] &&
                                                    !inj_q[abr_pkg::EI_CORR];
                        stat_q[abr_pkg::ST_CORR] <= inj_q[abr_pkg::EI_ARM] &&
                                                    inj_q[abr_pkg::EI_CORR];
                        state_q <= S_XFER;
                    end
                end
                S_XFER: begin
                    // no per-sector DRQ within a block
                    if (rd_data) begin
                        word_q <= word_q + 8'h01;
                    end
                    if (sector_end) begin
                        blk_left_q <= blk_left_q - 9'h001;
                        remain_q   <= remain_q - 17'h00001;
                        lba_q      <= lba_q + 48'h1;
                        // last sector LBA left in registers
                        if (!fatal_q && err_q == 8'h00) begin
                            {hi_q, mid_q, lo_q} <= lba_q[23:0];
                        end
                    end
                    // stop after block with uncorrectable error
                    if (last_sec || (blk_end && fatal_q)) begin
                        stat_q[abr_pkg::ST_DRQ] <= 1'b0;
                        state_q <= S_DONE;
                    end else if (blk_end) begin
                        stat_q <= 8'h00;
                        stat_q[abr_pkg::ST_BSY] <= 1'b1;
                        state_q <= S_FILL;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Interrupt: raised with DRQ for multiple reads and on abort, cleared by status read
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            intrq_q <= 1'b0;
        // one interrupt per block; with DRQ
        end else if (state_q == S_FILL && media_ack &&
                     cmd_q != abr_pkg::ABR_CMD_QUEUED) begin
            intrq_q <= 1'b1;
        end else if (wr_cmd && idle && abort) begin
            intrq_q <= 1'b1;
        end else if (rd_stat) begin
            intrq_q <= 1'b0;
        end
    end

    // ==========================================================
    // Read data, one cycle after strobe
    // HOB selects previous bytes on readback
    wire [7:0] lo_rd  = hob ? lo_prev_q[7:0]  : lo_q;
    wire [7:0] mid_rd = hob ? mid_prev_q[7:0] : mid_q;
    wire [7:0] hi_rd  = hob ? hi_prev_q[7:0]  : hi_q;
    wire [15:0] rd_mux =
        (bus.addr == abr_pkg::ADDR_DATA)     ? media_word :
        (bus.addr == abr_pkg::ADDR_FEATURES) ? {8'h00, err_q} :
        (bus.addr == abr_pkg::ADDR_SECCOUNT) ? remain_q[15:0] :
        (bus.addr == abr_pkg::ADDR_LBA_LOW)  ? {8'h00, lo_rd} :
        (bus.addr == abr_pkg::ADDR_LBA_MID)  ? {8'h00, mid_rd} :
        (bus.addr == abr_pkg::ADDR_LBA_HIGH) ? {8'h00, hi_rd} :
        (bus.addr == abr_pkg::ADDR_DEVHEAD)  ? {8'h00, dh_q} :
        (bus.addr == abr_pkg::ADDR_COMMAND)  ? {8'h00, stat_q} :
        (bus.addr == abr_pkg::ADDR_MULTSIZE) ? {7'h00, mult_q} :
                                               16'h0000;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (bus.rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign rdata            = rdata_q;
    assign intrq            = intrq_q;
    assign media.req        = state_q == S_FILL;
    assign media.lba        = lba_q;
    assign media.from_media = use_media;
    assign flush_req        = state_q == S_FLUSH;
    assign qtag             = cnt_cur_q[7:3];
    assign q_done           = cmd_q == abr_pkg::ABR_CMD_QUEUED &&
                              state_q == S_DONE;
endmodule
`default_nettype wire

// File: abr_read_engine_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module abr_read_engine_asserts (
    input  wire logic                ref_clk,    // Clock
    input  wire logic                rst,        // Reset
    input  wire abr_pkg::abr_bus_s   bus,        // Register port
    input  wire logic [15:0]         rdata,      // Read data
    input  wire logic                intrq,      // Interrupt
    input  wire abr_pkg::abr_media_s media,      // Fetch request
    input  wire logic                media_ack,  // Sector ready
    input  wire logic [15:0]         media_word, // Buffer word
    input  wire logic                flush_req,  // Commit request
    input  wire logic                flush_ack,  // Commit done
    input  wire logic [4:0]          qtag,       // Queue tag
    input  wire logic                q_done      // Queued done
);
    wire logic cmd_wr = bus.wr && bus.addr == abr_pkg::ADDR_COMMAND;
    wire logic op_mult = bus.wdata == abr_pkg::OPC_READ_MULT ||
                         bus.wdata == abr_pkg::OPC_READ_MULT_X;
    logic fua_q, dirty_q, valid_q, que_q, mult_q, flushed_q;

    // ==========================================================
    // Command tracking
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {fua_q, dirty_q, valid_q, que_q, mult_q, flushed_q} <= '0;
        end else begin
            if (bus.wr && bus.addr == abr_pkg::ADDR_DEVHEAD)
                fua_q <= bus.wdata[abr_pkg::DH_FUA_BIT];
            if (bus.wr && bus.addr == abr_pkg::ADDR_CACHE)
                {dirty_q, valid_q} <= bus.wdata[1:0];
            if (cmd_wr)
                que_q <= bus.wdata == abr_pkg::OPC_READ_QUEUED;
            if (cmd_wr)
                mult_q <= op_mult;
            flushed_q <= cmd_wr ? 1'b0 : (flushed_q | flush_ack);
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    property p_rdata_idle;
        !$past(bus.rd) |-> rdata == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("stray read data");
    property p_block_irq;
        media_ack && mult_q |=> intrq;
    endproperty
    a_block_irq: assert property (p_block_irq)
        else $error("no block interrupt");
    property p_irq_cause;
        $rose(intrq) |-> $past(media_ack) || $past(cmd_wr);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without cause");
    property p_status_clr;
        bus.rd && bus.addr == abr_pkg::ADDR_COMMAND && !media_ack |=> !intrq;
    endproperty
    a_status_clr: assert property (p_status_clr)
        else $error("interrupt not cleared");
    property p_fua_media;
        $rose(media.req) && que_q && fua_q |-> media.from_media;
    endproperty
    a_fua_media: assert property (p_fua_media)
        else $error("forced read used cache");
    property p_fua_flushed;
        $rose(media.req) && que_q && fua_q && dirty_q |-> flushed_q;
    endproperty
    a_fua_flushed: assert property (p_fua_flushed)
        else $error("fetch before commit");
    property p_cache_ok;
        $rose(media.req) && que_q && !fua_q && valid_q |-> !media.from_media;
    endproperty
    a_cache_ok: assert property (p_cache_ok)
        else $error("valid cache bypassed");
    property p_flush_only;
        flush_req |-> !media.req && que_q && fua_q && dirty_q;
    endproperty
    a_flush_only: assert property (p_flush_only)
        else $error("stray commit");
    property p_req_hold;
        media.req && !media_ack |=> media.req && $stable(media.lba);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("fetch request moved");
endmodule

bind abr_read_engine abr_read_engine_asserts u_asserts (
    .ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .intrq(intrq),
    .media(media), .media_ack(media_ack), .media_word(media_word),
    .flush_req(flush_req), .flush_ack(flush_ack), .qtag(qtag),
    .q_done(q_done));
`default_nettype wire

// File: tb_ata_block_read_commands.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ata_block_read_commands;
    logic                ref_clk, rst, intrq, flush_req, flush_ack;
    logic                media_ack, q_done, slow, pend_q;
    logic [15:0]         rdata, media_word, rv;
    logic [4:0]          qtag;
    logic [31:0]         seed;
    logic [31:0]         notes[$];
    abr_pkg::abr_bus_s   bus;
    abr_pkg::abr_media_s media;
    int                  failures, num_checks, n_ack, n_flush, cycles;

    abr_read_engine DUT (.ref_clk(ref_clk), .rst(rst), .bus(bus),
        .rdata(rdata), .intrq(intrq), .media(media), .media_ack(media_ack),
        .media_word(media_word), .flush_req(flush_req),
        .flush_ack(flush_ack), .qtag(qtag), .q_done(q_done));
    abr_media_model u_media (.ref_clk(ref_clk), .rst(rst), .media(media),
        .flush_req(flush_req), .slow(slow), .media_ack(media_ack),
        .media_word(media_word), .flush_ack(flush_ack), .n_ack(n_ack),
        .n_flush(n_flush));

    always #5 ref_clk = ~ref_clk;

    // ==========================================================
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus <= '0;
    endtask
    // Zero mask: poll, not compared
    task automatic rd(input logic [3:0] a, input logic [15:0] m,
                      input logic [15:0] e);
        notes.push_back({m, e});
        @(posedge ref_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus <= '0;
        @(negedge ref_clk);
        rv = rdata;
    endtask
    task automatic wait_irq;
        int k = 0;
        while (intrq !== 1'b1 && k < 400) begin
            @(negedge ref_clk);
            k++;
        end
        check("intrq", {15'h0, intrq}, 16'h0001);
    endtask

    // ==========================================================
    // Scenarios
    task automatic abort(input logic [7:0] bsz, input logic [7:0] op);
        wr(abr_pkg::ADDR_MULTSIZE, bsz);
        wr(abr_pkg::ADDR_SECCOUNT, 8'h01);
        wr(abr_pkg::ADDR_COMMAND, op);
        wait_irq();
        rd(abr_pkg::ADDR_COMMAND, 16'h0089, 16'h0001);
        rd(abr_pkg::ADDR_FEATURES, 16'h0004, 16'h0004);
    endtask
    task automatic mult(input logic [7:0] op, input logic [7:0] bsz,
                        input logic [15:0] cnt, input logic [1:0] inj);
        logic [31:0] hi, lo;
        logic [23:0] lba, last;
        logic [15:0] m, e;
        int left, blk, nblk = 0, a0;
        seed = lfsr(seed);
        lba = seed[23:0];
        hi = {seed[31:8], cnt[15:8]};
        lo = {lba, cnt[7:0]};
        a0 = n_ack;
        left = cnt;
        wr(abr_pkg::ADDR_MULTSIZE, bsz);
        for (int i = 0; i < 4; i++) begin
            wr(4'(abr_pkg::ADDR_SECCOUNT + i), hi[8*i+:8]);
            wr(4'(abr_pkg::ADDR_SECCOUNT + i), lo[8*i+:8]);
        end
        wr(abr_pkg::ADDR_DEVHEAD, 8'he0);
        wr(abr_pkg::ADDR_ERRINJ, {6'h0, inj});
        wr(abr_pkg::ADDR_COMMAND, op);
        while (left > 0) begin
            blk = left < bsz ? left : bsz;
            m = (nblk == 0 && inj[0]) ? 16'h008d : 16'h0089;
            e = (nblk == 0 && inj[0]) ? (inj[1] ? 16'h000c : 16'h0009)
                                      : 16'h0008;
            wait_irq();
            rd(abr_pkg::ADDR_COMMAND, m, e);
            repeat (blk * 256) rd(abr_pkg::ADDR_DATA, '1, 16'hc3a5);
            nblk++;
            left = (inj == 2'b01) ? 0 : left - blk;
        end
        repeat (20) @(negedge ref_clk);
        check("extra intrq", {15'h0, intrq}, 16'h0000);
        check("fills", 16'(n_ack - a0), 16'(nblk));
        rd(abr_pkg::ADDR_COMMAND, 16'h0088, 16'h0000);
        if (inj == 2'b01)
            rd(abr_pkg::ADDR_FEATURES, 16'h0040, 16'h0040);
        last = (inj == 2'b01) ? lba : lba + 24'(cnt) - 24'h1;
        for (int h = 0; h < 2; h++) begin
            wr(abr_pkg::ADDR_DEVCTRL, {h[0], 7'h00});
            for (int i = 0; i < 3; i++)
                rd(4'(abr_pkg::ADDR_LBA_LOW + i), 16'h00ff,
                   {8'h0, h ? hi[8*i+8+:8] : last[8*i+:8]});
        end
    endtask
    task automatic queued(input logic fua, input logic [7:0] cache);
        int a0, f0, k = 0;
        logic [4:0] tag;
        seed = lfsr(seed);
        tag = seed[4:0];
        a0 = n_ack;
        f0 = n_flush;
        wr(abr_pkg::ADDR_CACHE, cache);
        wr(abr_pkg::ADDR_FEATURES, 8'h00);
        wr(abr_pkg::ADDR_FEATURES, 8'h02);
        wr(abr_pkg::ADDR_SECCOUNT, {tag, 3'h0});
        wr(abr_pkg::ADDR_DEVHEAD, {fua, 7'h40});
        wr(abr_pkg::ADDR_COMMAND, abr_pkg::OPC_READ_QUEUED);
        repeat (2) @(negedge ref_clk);
        while (q_done !== 1'b1 && k < 3000) begin
            rd(abr_pkg::ADDR_COMMAND, 16'h0000, 16'h0000);
            if (rv[abr_pkg::ST_DRQ])
                repeat (256) rd(abr_pkg::ADDR_DATA, 16'hffff, 16'hc3a5);
            k++;
        end
        check("q_done", {15'h0, q_done}, 16'h0001);
        check("qtag", {11'h0, qtag}, {11'h0, tag});
        check("intrq", {15'h0, intrq}, 16'h0000);
        check("fills", 16'(n_ack - a0), 16'h0002);
        check("commits", 16'(n_flush - f0), 16'(fua & cache[1]));
    endtask

    // ==========================================================
    // Result watcher and timeout
    always @(posedge ref_clk) begin
        logic [31:0] n;
        if (pend_q && notes.size() > 0) begin
            n = notes.pop_front();
            if (n[31:16] !== 16'h0000)
                check("rdata", rdata & n[31:16], n[15:0]);
        end
        pend_q <= bus.rd;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        bus = '0;
        slow = 1'b0;
        pend_q = 1'b0;
        seed = 32'h5d31ea7e;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        rd(abr_pkg::ADDR_COMMAND, '1, {8'h0, abr_pkg::ST_RESET});
        check("intrq", {15'h0, intrq}, 16'h0000);
        abort(8'h00, abr_pkg::OPC_READ_MULT);
        abort(8'h00, abr_pkg::OPC_READ_MULT_X);
        abort(8'h81, abr_pkg::OPC_READ_MULT);
        abort(8'h04, 8'h61);
        mult(abr_pkg::OPC_READ_MULT, 8'h01, 16'h0002, 2'b00);
        mult(abr_pkg::OPC_READ_MULT, 8'h04, 16'h000a, 2'b00);
        @(posedge ref_clk);
        slow <= 1'b1;
        mult(abr_pkg::OPC_READ_MULT_X, 8'h02, 16'h0003, 2'b00);
        mult(abr_pkg::OPC_READ_MULT, 8'h02, 16'h0005, 2'b01);
        mult(abr_pkg::OPC_READ_MULT, 8'h02, 16'h0003, 2'b11);
        queued(1'b1, 8'h03);
        @(posedge ref_clk);
        slow <= 1'b0;
        queued(1'b0, 8'h01);
        test_done();
    end
endmodule
`default_nettype wire
